// ==== common/serial_rx_pkg.sv ====
/*
  Constants and carrier types for the asynchronous serial receiver.
  Assumes a 20 MHz system clock and a sixteen-times sample tick supplied
  by a shared baud divider outside this block.

*/
package serial_rx_pkg;
	// Slot numbers within a bit (counter runs 1..16)
	localparam logic [3:0] SLOT_Q1 = 4'h3;
	localparam logic [3:0] SLOT_Q2 = 4'h5;
	localparam logic [3:0] SLOT_Q3 = 4'h7;
	localparam logic [3:0] SLOT_M1 = 4'h8;
	localparam logic [3:0] SLOT_M2 = 4'h9;
	localparam logic [3:0] SLOT_M3 = 4'hA;
	localparam logic [3:0] SLOT_LAST = 4'h0;
	localparam logic [3:0] SLOT_FIRST = 4'h1;
	// Bit counts
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	localparam logic [3:0] IDLE_BITS_8 = 4'hA;
	localparam logic [3:0] IDLE_BITS_9 = 4'hB;
	// Reset values
	localparam logic [2:0] HIST_RESET = 3'h0;
	localparam logic [2:0] HIST_ONES = 3'h7;
	localparam logic [8:0] DATA_RESET = 9'h000;
	localparam logic [3:0] COUNT_RESET = 4'h0;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_START = 2'b01,
		ST_BITS = 2'b10
	} rx_state_type;

	typedef struct packed {
		logic rxOn;
		logic polarityInvert;
		logic nineBit;
		logic wakeAddress;
		logic idleCountStart;
		logic idleFlagDuringSleep;
	} rx_ctrl_type;

	typedef struct packed {
		logic rxFull;
		logic idle;
		logic overrun;
		logic noise;
		logic framingError;
		logic parityError;
	} rx_status_type;
endpackage

// ==== testbench/async_serial_receiver_asserts.sv ====
/* Port assertions for the serial receiver.
   Sees only the top ports; bound from tb. */
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Tick and line
	input wire logic sampleTick,
	input wire logic rxLine,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [8:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [8:0] regRdData
);
	logic everOn_ff;
	logic everNine_ff;
	logic stRd;
	logic dtRd;
	logic ctrlWr;
	assign stRd = regRd && regAddr == 2'h0;
	assign dtRd = regRd && regAddr == 2'h1;
	assign ctrlWr = regWr && regAddr == 2'h2;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			everOn_ff <= 1'b0;
			everNine_ff <= 1'b0;
		end else if (ctrlWr) begin
			everOn_ff <= everOn_ff | regWrData[5];
			everNine_ff <= everNine_ff | regWrData[3];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_rdQuiet; !regRd |=> regRdData == 9'h000; endproperty
	a_rdQuiet: assert property (p_rdQuiet) else $error("read data while idle");
	property p_pastRd; regRdData != 9'h000 |-> $past(regRd); endproperty
	a_pastRd: assert property (p_pastRd) else $error("data without read");
	property p_noParity; stRd |=> !regRdData[0]; endproperty
	a_noParity: assert property (p_noParity) else $error("parity flag set");
	property p_statusTop; stRd |=> regRdData[8:6] == 3'h0; endproperty
	a_statusTop: assert property (p_statusTop) else $error("status top bits");
	property p_offStatus; stRd && !everOn_ff |=> regRdData == 9'h000; endproperty
	a_offStatus: assert property (p_offStatus) else $error("flags while off");
	property p_offData; dtRd && !everOn_ff |=> regRdData == 9'h000; endproperty
	a_offData: assert property (p_offData) else $error("data while off");
	property p_clear; stRd ##2 dtRd ##2 stRd |=> regRdData[5:4] == 2'b00; endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
	property p_eightBit; dtRd && !everNine_ff |=> !regRdData[8]; endproperty
	a_eightBit: assert property (p_eightBit) else $error("ninth bit in 8-bit");
	cover property (stRd ##1 regRdData[5]);
	cover property (stRd ##1 regRdData[3]);
	cover property (regWr && regAddr == 2'h3);
endmodule
`default_nettype wire

// ==== testbench/serial_tx_model.sv ====
/* Remote serial transmitter on the receive line.
   Assumes sampleTick at sixteen times the baud rate. */
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
	// Clock and tick
	input wire logic clk_sys,
	input wire logic sampleTick,
	// Line
	input wire logic invert,
	output logic rxLine
);
	logic bit_ff = 1'b1;
	assign rxLine = bit_ff ^ invert;
	task automatic sendBit(input logic b);
		bit_ff <= b;
		repeat (16) @(posedge clk_sys iff sampleTick);
	endtask
	task automatic send(input logic [8:0] d, input int n, input logic stopBit);
		// Idle bit first so the edge search has three highs
		sendBit(1'b1);
		sendBit(1'b0);
		for (int i = 0; i < n; i++) sendBit(d[i]);
		sendBit(stopBit);
		bit_ff <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench for the serial receiver.
   Makes clock, tick and reset; line from serial_tx_model. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic sampleTick = 1'b0;
	logic rxLine;
	logic invert = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [8:0] regWrData = 9'h000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [8:0] regRdData;
	logic [1:0] tickCnt = 2'h0;
	int bad_count = 0;
	int checked = 0;
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		tickCnt <= tickCnt + 2'h1;
		sampleTick <= (tickCnt == 2'h3);
	end
	async_serial_receiver i_async_serial_receiver (.clk_sys(clk_sys), .rstn(rstn),
		.sampleTick(sampleTick), .rxLine(rxLine), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	serial_tx_model i_serial_tx_model (.clk_sys(clk_sys), .sampleTick(sampleTick),
		.invert(invert), .rxLine(rxLine));
	task automatic wr(input logic [1:0] a, input logic [8:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [8:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		d = regRdData;
	endtask
	task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Status then data read, which also clears the flags
	task automatic take(input logic [5:0] st, input logic [8:0] d);
		logic [8:0] v;
		rd(2'h0, v);
		cmp("status", {3'h0, st}, v);
		rd(2'h1, v);
		cmp("data", d, v);
	endtask
	task automatic t_basic();
		logic [8:0] v;
		i_serial_tx_model.send(9'h0A5, 8, 1'b1);
		rd(2'h0, v);
		cmp("status off", 9'h000, v);
		rd(2'h1, v);
		cmp("data off", 9'h000, v);
		wr(2'h2, 9'h020);
		i_serial_tx_model.send(9'h0A5, 8, 1'b1);
		take(6'h20, 9'h0A5);
		rd(2'h0, v);
		cmp("status cleared", 9'h000, v);
		$display("test basic done");
	endtask
	task automatic t_overrun();
		i_serial_tx_model.send(9'h03C, 8, 1'b1);
		i_serial_tx_model.send(9'h055, 8, 1'b1);
		take(6'h28, 9'h03C);
		$display("test overrun done");
	endtask
	task automatic t_frame();
		i_serial_tx_model.send(9'h081, 8, 1'b0);
		// Preloaded history finds a start in the low stop bit; let it finish
		repeat (192) @(posedge clk_sys iff sampleTick);
		take(6'h32, 9'h081);
		$display("test framing done");
	endtask
	task automatic t_wake();
		logic [8:0] v;
		wr(2'h2, 9'h024);
		wr(2'h3, 9'h001);
		i_serial_tx_model.send(9'h012, 8, 1'b1);
		rd(2'h0, v);
		cmp("status asleep", 9'h000, v);
		i_serial_tx_model.send(9'h092, 8, 1'b1);
		take(6'h20, 9'h092);
		$display("test wake done");
	endtask
	task automatic t_nine();
		for (int k = 0; k < 2; k++) begin
			wr(2'h2, 9'h000);
			invert <= (k == 1);
			wr(2'h2, (k == 1) ? 9'h038 : 9'h028);
			i_serial_tx_model.send(9'h1C3, 9, 1'b1);
			take(6'h20, 9'h1C3);
		end
		$display("test nine done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_basic();
		t_overrun();
		t_frame();
		t_wake();
		t_nine();
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		report_and_stop();
	end
endmodule
bind async_serial_receiver async_serial_receiver_asserts i_async_serial_receiver_asserts (
	.clk_sys(clk_sys), .rstn(rstn), .sampleTick(sampleTick), .rxLine(rxLine),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData));
`default_nettype wire

// ==== verilog/async_serial_receiver.sv ====
/*
  Receive half of an asynchronous NRZ serial port with sleep and wakeup.
  Assumes a one-cycle sampleTick at sixteen times the baud rate from a
  shared divider, and a plain register port: status and data reads, and
  writes to the control and sleep registers. Reads answer one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver
	import serial_rx_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Sample tick from the baud divider
	input wire logic sampleTick,
	// Serial line
	input wire logic rxLine,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [8:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [8:0] regRdData
);
	// Register indices
	localparam logic [1:0] ADDR_STATUS = 2'h0;
	localparam logic [1:0] ADDR_DATA = 2'h1;
	localparam logic [1:0] ADDR_CONTROL = 2'h2;
	localparam logic [1:0] ADDR_SLEEP = 2'h3;

	logic rstMeta_ff, rstSync_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end
	wire rstSyncN = rstSync_ff;

	// Line synchroniser: three stages, change accepted when last two agree
	logic [2:0] lineSync_ff;
	logic lineLevel_ff;
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN) begin
			lineSync_ff <= HIST_ONES;
			lineLevel_ff <= 1'b1;
		end else begin
			lineSync_ff <= {lineSync_ff[1:0], rxLine};
			if (lineSync_ff[1] == lineSync_ff[2])
				lineLevel_ff <= lineSync_ff[2];
		end
	end

	rx_ctrl_type ctrl_ff;
	logic sleep_ff;
	rx_status_type flags;
	logic rxFull_ff;
	logic idle_ff;
	logic overrun_ff;
	logic noise_ff;
	logic framing_ff;
	logic [8:0] rxBuf_ff;
	logic statusSeen_ff;
	logic idleArmed_ff;

	wire rxIn = lineLevel_ff ^ ctrl_ff.polarityInvert;
	wire tickOn = sampleTick && ctrl_ff.rxOn;

	rx_state_type state_ff, nxt_state;
	logic [3:0] slot_ff;
	logic [2:0] hist_ff;
	logic [3:0] bitCnt_ff;
	logic [8:0] shift_ff;
	logic [2:0] votes_ff;
	logic [2:0] qual_ff;
	logic noiseAcc_ff;
	logic allLow_ff;
	logic [3:0] idleBits_ff;
	logic idleCounting_ff;

	wire [3:0] dataBits = ctrl_ff.nineBit ? DATA_BITS_9 : DATA_BITS_8;
	wire [3:0] idleNeed = ctrl_ff.nineBit ? IDLE_BITS_9 : IDLE_BITS_8;
	wire edgeSeen = (hist_ff == HIST_ONES) && !rxIn;
	wire atQ3 = (slot_ff == SLOT_Q3);
	wire atM3 = (slot_ff == SLOT_M3);
	wire atEnd = (slot_ff == SLOT_LAST);
	wire isVoteSlot = (slot_ff == SLOT_M1) || (slot_ff == SLOT_M2) || atM3;
	wire isQualSlot = (slot_ff == SLOT_Q1) || (slot_ff == SLOT_Q2) || atQ3;
	wire [2:0] qualNow = {qual_ff[1:0], rxIn};
	wire [2:0] votesNow = {votes_ff[1:0], rxIn};
	wire qualLow = (qualNow[0] + qualNow[1] + qualNow[2]) < 2'd2;
	wire majority = (votesNow[0] & votesNow[1]) | (votesNow[0] & votesNow[2])
		| (votesNow[1] & votesNow[2]);
	wire voteNoisy = !(&votesNow) && (|votesNow);
	wire qualNoisy = !(&qualNow) && (|qualNow);
	wire lastBit = (bitCnt_ff == dataBits);
	wire stopBitDone = tickOn && (state_ff == ST_BITS) && atM3 && (bitCnt_ff > dataBits);
	wire stopHigh = majority;
	wire frameNoise = noiseAcc_ff || voteNoisy;
	wire isBreak = allLow_ff && !stopHigh;
	wire framing = !stopHigh;
	// Most significant data bit decided high this cycle
	wire msbDecided = tickOn && (state_ff == ST_BITS) && atM3 && lastBit && majority;
	wire canTransfer = !framing_ff;
	wire doTransfer = stopBitDone && canTransfer && !rxFull_ff;
	wire doOverrun = stopBitDone && canTransfer && rxFull_ff;
	wire [8:0] newChar = ctrl_ff.nineBit ? shift_ff : {1'b0, shift_ff[8:1]};
	wire addrWake = sleep_ff && ctrl_ff.wakeAddress && msbDecided;
	wire sleepNow = sleep_ff && !addrWake;
	wire idleHit = idleCounting_ff && tickOn && atEnd && (idleBits_ff == idleNeed - 4'h1)
		&& rxIn && (state_ff == ST_HUNT);
	wire idleWake = idleHit && sleep_ff && !ctrl_ff.wakeAddress;
	wire idleSet = idleHit && idleArmed_ff
		&& (!sleep_ff || ctrl_ff.idleFlagDuringSleep);

	wire rdStatus = regRd && (regAddr == ADDR_STATUS);
	wire rdData = regRd && (regAddr == ADDR_DATA);
	wire rdControl = regRd && (regAddr == ADDR_CONTROL);
	wire rdSleep = regRd && (regAddr == ADDR_SLEEP);
	wire wrControl = regWr && (regAddr == ADDR_CONTROL);
	wire wrSleep = regWr && (regAddr == ADDR_SLEEP);
	wire clearSeq = rdData && statusSeen_ff;

	always_comb begin
		nxt_state = state_ff;
		if (!ctrl_ff.rxOn)
			nxt_state = ST_HUNT;
		else if (tickOn) begin
			unique case (state_ff)
				ST_HUNT: begin
					if (edgeSeen)
						nxt_state = ST_START;
				end
				ST_START: begin
					if (atQ3)
						nxt_state = qualLow ? ST_BITS : ST_HUNT;
				end
				ST_BITS: begin
					if (stopBitDone)
						nxt_state = ST_HUNT;
				end
			endcase
		end
	end

	// Frame events on the current tick
	wire frameStart = (state_ff == ST_HUNT) && edgeSeen;
	wire resync = (state_ff == ST_BITS) && edgeSeen && (slot_ff > SLOT_M3);
	wire bitDecide = (state_ff == ST_BITS) && atM3;
	wire dataSlot = bitDecide && (bitCnt_ff != COUNT_RESET) && (bitCnt_ff <= dataBits);
	wire preload = stopBitDone && framing && !isBreak;

	// State register
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			state_ff <= ST_HUNT;
		else
			state_ff <= nxt_state;
	end

	// Edge search history
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			hist_ff <= HIST_RESET;
		else if (!ctrl_ff.rxOn)
			hist_ff <= HIST_RESET;
		else if (tickOn && preload)
			hist_ff <= HIST_ONES;
		else if (tickOn)
			hist_ff <= {hist_ff[1:0], rxIn};
	end

	// Sixteenth-bit slot counter
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			slot_ff <= COUNT_RESET;
		else if (!ctrl_ff.rxOn)
			slot_ff <= COUNT_RESET;
		else if (tickOn && (frameStart || resync))
			slot_ff <= SLOT_FIRST;
		else if (tickOn)
			slot_ff <= slot_ff + 4'h1;
	end

	// Bit counter, start bit is count zero
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			bitCnt_ff <= COUNT_RESET;
		else if (tickOn && frameStart)
			bitCnt_ff <= COUNT_RESET;
		else if (tickOn && bitDecide)
			bitCnt_ff <= bitCnt_ff + 4'h1;
	end

	// Shifter skips the start bit, taken as low regardless
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			shift_ff <= DATA_RESET;
		else if (tickOn && dataSlot)
			shift_ff <= {majority, shift_ff[8:1]};
	end

	// Break detection: every data bit low
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			allLow_ff <= 1'b0;
		else if (tickOn && frameStart)
			allLow_ff <= 1'b1;
		else if (tickOn && dataSlot && majority)
			allLow_ff <= 1'b0;
	end

	// Qualification and vote samples
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN) begin
			qual_ff <= HIST_RESET;
			votes_ff <= HIST_RESET;
		end else if (tickOn) begin
			if (isQualSlot)
				qual_ff <= qualNow;
			if (isVoteSlot)
				votes_ff <= votesNow;
		end
	end

	// Noise gathered over the frame
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			noiseAcc_ff <= 1'b0;
		else if (tickOn && frameStart)
			noiseAcc_ff <= 1'b0;
		else if (tickOn && (state_ff == ST_START) && atQ3 && qualNoisy)
			noiseAcc_ff <= 1'b1;
		else if (tickOn && bitDecide && voteNoisy)
			noiseAcc_ff <= 1'b1;
	end

	// Idle bit counter
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN) begin
			idleBits_ff <= COUNT_RESET;
			idleCounting_ff <= 1'b0;
		end else if (!ctrl_ff.rxOn) begin
			idleBits_ff <= COUNT_RESET;
			idleCounting_ff <= 1'b0;
		end else if (tickOn) begin
			if (!rxIn) begin
				idleBits_ff <= COUNT_RESET;
				idleCounting_ff <= ctrl_ff.idleCountStart ? 1'b0 : 1'b1;
			end else if (stopBitDone)
				idleCounting_ff <= 1'b1;
			else if (idleCounting_ff && atEnd) begin
				if (idleHit) begin
					idleCounting_ff <= 1'b0;
					idleBits_ff <= COUNT_RESET;
				end else
					idleBits_ff <= idleBits_ff + 4'h1;
			end
		end
	end

	// Flag events; sleep suppresses all, idle too unless idleFlagDuringSleep
	wire acceptChar = doTransfer && !sleepNow;
	wire markOverrun = doOverrun && !sleepNow;
	// No parity logic, so that flag stays low
	assign flags = {rxFull_ff, idle_ff, overrun_ff, noise_ff, framing_ff, 1'b0};

	// Read data selection
	wire [8:0] statusWord = {3'h0, flags};
	wire [8:0] controlWord = {3'h0, ctrl_ff};
	wire [8:0] sleepWord = {8'h00, sleep_ff};
	wire [8:0] readWord = rdStatus ? statusWord
		: rdData ? rxBuf_ff
		: rdControl ? controlWord
		: rdSleep ? sleepWord
		: DATA_RESET;

	// Control register
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			ctrl_ff <= '0;
		else if (wrControl)
			ctrl_ff <= regWrData[5:0];
	end

	// Sleep: a wake event beats a write in the same cycle
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			sleep_ff <= 1'b0;
		else if (addrWake || idleWake)
			sleep_ff <= 1'b0;
		else if (wrSleep)
			sleep_ff <= regWrData[0];
	end

	// First step of the clearing sequence
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			statusSeen_ff <= 1'b0;
		else if (rdStatus)
			statusSeen_ff <= rxFull_ff || idle_ff;
		else if (rdData)
			statusSeen_ff <= 1'b0;
	end

	// Receive buffer
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			rxBuf_ff <= DATA_RESET;
		else if (acceptChar)
			rxBuf_ff <= newChar;
	end

	// Full flag; a set in the clearing cycle wins
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			rxFull_ff <= 1'b0;
		else if (acceptChar)
			rxFull_ff <= 1'b1;
		else if (clearSeq)
			rxFull_ff <= 1'b0;
	end

	// Idle flag
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			idle_ff <= 1'b0;
		else if (idleSet)
			idle_ff <= 1'b1;
		else if (clearSeq)
			idle_ff <= 1'b0;
	end

	// Idle rearms only after a received character
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			idleArmed_ff <= 1'b1;
		else if (acceptChar)
			idleArmed_ff <= 1'b1;
		else if (idleSet)
			idleArmed_ff <= 1'b0;
	end

	// Overrun flag
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			overrun_ff <= 1'b0;
		else if (markOverrun)
			overrun_ff <= 1'b1;
		else if (clearSeq)
			overrun_ff <= 1'b0;
	end

	// Noise flag
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			noise_ff <= 1'b0;
		else if (acceptChar)
			noise_ff <= frameNoise;
		else if (clearSeq)
			noise_ff <= 1'b0;
	end

	// Framing error flag
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			framing_ff <= 1'b0;
		else if (acceptChar)
			framing_ff <= framing;
		else if (clearSeq)
			framing_ff <= 1'b0;
	end

	// Read data, zero outside the answer cycle
	always_ff @(posedge clk_sys or negedge rstSyncN) begin
		if (!rstSyncN)
			regRdData <= DATA_RESET;
		else
			regRdData <= readWord;
	end
endmodule
`default_nettype wire
